// [design/spf_pkg.sv]
// Purpose: constants and types for the spindle feedback configuration block
// Assumes: 32-bit APB, one clock, registers are one aligned word each
// Notes: parameter words are 16 bits wide and sit in the low half of a word
`default_nettype none
package spf_pkg;
    // register byte offsets
    localparam logic [7:0] SPF_OFF_SUB_RES = 8'h00;
    localparam logic [7:0] SPF_OFF_MAIN_RES = 8'h04;
    localparam logic [7:0] SPF_OFF_SUB_EXT = 8'h08;
    localparam logic [7:0] SPF_OFF_MAIN_EXT = 8'h0c;
    localparam logic [7:0] SPF_OFF_LOOP = 8'h10;
    localparam logic [7:0] SPF_OFF_ORE = 8'h14;
    localparam logic [7:0] SPF_OFF_FUNC7 = 8'h18;
    localparam logic [7:0] SPF_OFF_FUNC5 = 8'h1c;
    localparam logic [7:0] SPF_OFF_ZRN = 8'h20;
    localparam logic [7:0] SPF_OFF_MAXSPD = 8'h24;
    localparam logic [7:0] SPF_OFF_STATUS = 8'h28;
    localparam logic [7:0] SPF_OFF_INT_STAT = 8'h2c;
    localparam logic [7:0] SPF_OFF_INT_EN = 8'h30;
    localparam logic [7:0] SPF_OFF_INT_CLR = 8'h34;
    localparam logic [7:0] SPF_OFF_SUB_PULSES = 8'h38;
    localparam logic [7:0] SPF_OFF_MAIN_PULSES = 8'h3c;
    // reset values
    localparam logic [15:0] SPF_RST_RES = 16'h07d0;      // 2000
    localparam logic [15:0] SPF_RST_MAXSPD = 16'h2710;   // 10000 r/min
    // control loop type codes
    localparam logic [15:0] SPF_LOOP_SEMI = 16'h0898;    // 2200
    localparam logic [15:0] SPF_LOOP_FULL_ABZ = 16'h1068; // 4200
    localparam logic [15:0] SPF_LOOP_FULL_SER = 16'h1838; // 6200
    // resolution handling
    localparam logic [31:0] SPF_KP_SCALE = 32'h000003e8; // 1000 pulses per kp
    localparam logic [15:0] SPF_ABZ_RES = 16'h1000;      // 4096
    localparam logic [15:0] SPF_NEG1 = 16'hffff;         // -1 as a word
    localparam logic [15:0] SPF_WORD_MAX = 16'h7fff;     // 32767
    // overrun detection
    localparam logic [15:0] SPF_ORE_DEFAULT = 16'h0002;  // 2 degrees
    localparam logic [8:0] SPF_DEG_REV = 9'h168;         // 360 degrees
    localparam logic [6:0] SPF_SPD_PCT = 7'h1e;          // 30 percent
    localparam logic [6:0] SPF_PCT_FULL = 7'h64;         // 100 percent
    localparam logic [7:0] SPF_ALARM_OVERRUN = 8'h2b;    // alarm 43
    // field positions
    localparam int SPF_DIS_HI = 15;
    localparam int SPF_DIS_LO = 12;
    localparam logic [3:0] SPF_DIS_NONE = 4'h0;
    localparam logic [3:0] SPF_DIS_PROX = 4'h4;
    localparam int SPF_DDIR_BIT = 5;
    localparam int SPF_ZRN_PROX_BIT = 15;
    // interrupt bits
    localparam int SPF_IRQ_OVERRUN = 0;
    localparam int SPF_IRQ_CFG = 1;
    localparam int SPF_IRQ_ZDONE = 2;
    localparam int SPF_IRQ_PROX = 3;
    localparam int SPF_NIRQ = 4;

    typedef enum logic [1:0] {SPF_ZD_IDLE, SPF_ZD_RUN, SPF_ZD_DONE} spf_zd_t;

    // encoder feedback presented each cycle
    typedef struct packed {
        logic signed [31:0] motor_count;
        logic signed [31:0] machine_count;
        logic signed [15:0] motor_speed;
        logic signed [15:0] machine_speed;
    } spf_fb_t;

    // whole state of the block
    typedef struct packed {
        logic [15:0] sub_res;
        logic [15:0] main_res;
        logic [15:0] sub_ext;
        logic [15:0] main_ext;
        logic [15:0] loop_type;
        logic [15:0] overrun_width;
        logic [15:0] func7;
        logic [15:0] func5;
        logic [15:0] zrn;
        logic [15:0] maxspd;
        logic [SPF_NIRQ-1:0] int_stat;
        logic [SPF_NIRQ-1:0] int_en;
        logic [7:0] cfg_err;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
        logic alarm;
        spf_zd_t zd;
        logic zdet;
        logic [1:0] z_count;
        logic prox_prev;
        logic prox_seen;
    } spf_state_t;
endpackage
`default_nettype wire

// [design/spf_feedback.sv]
// Purpose: spindle encoder resolution decode, loop type, overrun alarm, proximity zero detect
// Assumes: all inputs synchronous to clk; encoder counts are zeroed together by the system
// Notes: APB slave answers with one wait state; alarm 43 is a sticky status bit
//
// Overview of operation
// R01 - In semi-closed loop the sub side resolution must equal the main side resolution.
// R02 - In full-closed loop the sub side resolution is the machine encoder pulses per turn.
// R03 - An ABZ machine encoder needs sub resolution 4096 with its extension word at -1.
// R04 - A zero sub extension makes the sub resolution kilopulses, range 0 to 32767.
// R05 - A zero main extension makes the main resolution kilopulses, else pulses to 65535.
// R06 - The main side resolution is the motor encoder pulses per turn.
// R07 - In pulse units the sub resolution is extension high and word low, extension -1..32767.
// R08 - In pulse units the main resolution is extension high and word low.
// R09 - Loop type 2200 is semi-closed, 4200 full-closed ABZ, 6200 full-closed serial.
// R10 - In full-closed loop a position gap above the overrun width in degrees raises alarm 43.
// R11 - With overrun width -1, a speed gap above 30% of maximum motor speed raises alarm 43.
// R12 - Overrun width 0 means a 2 degree threshold; the setting range is -1 to 32767.
// R13 - Software should set the overrun width to 360 normally and to -1 for belt drive.
// R14 - The input selection field in bits 15..12 allows 0 for none and 4 for proximity only.
// R15 - Bit 5 of spindle function word 5 picks the proximity edge, 0 falling, 1 rising.
// R16 - Bit 15 of the zero return word enables zero point detection by proximity switch.
// R17 - The first speed command runs at Z detect speed until Z is seen twice, with proximity; the code runs this search even without proximity selected.
`default_nettype none
module spf_feedback
    import spf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire spf_fb_t fb_in,
    input wire logic speed_cmd,
    input wire logic z_phase,
    input wire logic prox_in,
    output logic zdet_active,
    output logic prox_seen,
    output logic alarm_overrun,
    output logic irq
);
    spf_state_t st, nx;

    // decoded resolutions and checks
    logic [31:0] sub_pulses, main_pulses;
    logic full_loop, semi_loop, speed_mode;
    logic [15:0] width_eff;
    logic signed [65:0] prod_m, prod_s, pos_diff;
    logic [65:0] pos_abs;
    logic [81:0] gap_lhs, gap_rhs;
    logic signed [16:0] spd_diff;
    logic [16:0] spd_abs;
    logic [24:0] spd_lhs, spd_rhs;
    logic gap_over, spd_over, overrun_hit;
    logic [7:0] cfg_now;
    logic prox_edge, sel_prox;
    logic wr_en, rd_en, mapped;
    logic [7:0] off;

    // word plus extension to pulses per turn
    function automatic logic [31:0] res_pulses(input logic [15:0] word, input logic [15:0] ext);
        logic [31:0] r;
        r = {ext, word};
        if (ext == 16'h0000) begin
            r = {16'h0000, word} * SPF_KP_SCALE;
        end else if (ext == SPF_NEG1) begin
            r = {16'h0000, word};
        end
        return r;
    endfunction

    // R04 sub kilopulse unit
    // R07 sub pulse unit join
    assign sub_pulses = res_pulses(st.sub_res, st.sub_ext);
    // R05 main unit select
    // R08 main pulse unit join
    assign main_pulses = res_pulses(st.main_res, st.main_ext);

    // R09 loop type decode
    assign semi_loop = (st.loop_type == SPF_LOOP_SEMI);
    assign full_loop = (st.loop_type == SPF_LOOP_FULL_ABZ) || (st.loop_type == SPF_LOOP_FULL_SER);

    // R12 zero width default
    assign speed_mode = (st.overrun_width == SPF_NEG1);
    assign width_eff = (st.overrun_width == 16'h0000) ? SPF_ORE_DEFAULT : st.overrun_width;

    // R02 machine pulses per turn
    // R06 motor pulses per turn
    // angles compared by cross multiplying, which avoids a divider at the cost of area
    assign prod_m = $signed({{34{fb_in.motor_count[31]}}, fb_in.motor_count})
        * $signed({34'h0, sub_pulses});
    assign prod_s = $signed({{34{fb_in.machine_count[31]}}, fb_in.machine_count})
        * $signed({34'h0, main_pulses});
    assign pos_diff = prod_m - prod_s;
    assign pos_abs = pos_diff[65] ? 66'(-pos_diff) : 66'(pos_diff);
    assign gap_lhs = 82'(pos_abs) * 82'(SPF_DEG_REV);
    assign gap_rhs = 82'(width_eff) * 82'(main_pulses) * 82'(sub_pulses);
    // R10 position gap compare
    assign gap_over = gap_lhs > gap_rhs;

    // R11 speed gap compare
    assign spd_diff = $signed({fb_in.motor_speed[15], fb_in.motor_speed})
        - $signed({fb_in.machine_speed[15], fb_in.machine_speed});
    assign spd_abs = spd_diff[16] ? 17'(-spd_diff) : 17'(spd_diff);
    assign spd_lhs = 25'(spd_abs) * 25'(SPF_PCT_FULL);
    assign spd_rhs = 25'(st.maxspd) * 25'(SPF_SPD_PCT);
    assign spd_over = spd_lhs > spd_rhs;

    // R10 overrun only in full loop
    assign overrun_hit = full_loop && (speed_mode ? spd_over : gap_over);

    // configuration checks, one bit each
    always_comb begin
        cfg_now = 8'h00;
        // R09 unknown loop code
        cfg_now[0] = !(semi_loop || full_loop);
        // R01 semi loop equality
        cfg_now[1] = semi_loop && ({st.sub_ext, st.sub_res} != {st.main_ext, st.main_res});
        // R03 abz encoder setting
        cfg_now[2] = (st.loop_type == SPF_LOOP_FULL_ABZ)
            && !((st.sub_res == SPF_ABZ_RES) && (st.sub_ext == SPF_NEG1));
        // R07 sub extension range, and the same range check on the main extension
        cfg_now[3] = st.sub_ext[15] && (st.sub_ext != SPF_NEG1);
        cfg_now[4] = st.main_ext[15] && (st.main_ext != SPF_NEG1);
        // R04 kilopulse range
        cfg_now[5] = ((st.sub_ext == 16'h0000) && (st.sub_res > SPF_WORD_MAX))
            || ((st.main_ext == 16'h0000) && (st.main_res > SPF_WORD_MAX));
        // R12 overrun width range
        cfg_now[6] = st.overrun_width[15] && !speed_mode;
        // R14 input selection codes
        cfg_now[7] = (st.func7[SPF_DIS_HI:SPF_DIS_LO] != SPF_DIS_NONE)
            && (st.func7[SPF_DIS_HI:SPF_DIS_LO] != SPF_DIS_PROX);
    end

    // R14 proximity input only when selected
    // R16 proximity zero point enable
    assign sel_prox = (st.func7[SPF_DIS_HI:SPF_DIS_LO] == SPF_DIS_PROX)
        && st.zrn[SPF_ZRN_PROX_BIT];
    // R15 edge select
    assign prox_edge = st.func5[SPF_DDIR_BIT] ? (prox_in && !st.prox_prev)
        : (!prox_in && st.prox_prev);

    // bus decode, transfer completes on the edge where pready is high
    assign off = paddr[7:0];
    // unmapped writes must not alias onto a register through the low address byte
    assign wr_en = psel && penable && st.pready && pwrite && mapped;
    assign rd_en = psel && penable && !st.pready && !pwrite;
    always_comb begin
        mapped = 1'b1;
        if (paddr[31:8] != 24'h0 || paddr[1:0] != 2'b00) begin
            mapped = 1'b0;
        end else if (off > SPF_OFF_MAIN_PULSES) begin
            mapped = 1'b0;
        end
    end

    // next state of the whole block
    always_comb begin
        logic [SPF_NIRQ-1:0] set_ev;
        logic [SPF_NIRQ-1:0] clr_ev;
        set_ev = '0;
        clr_ev = '0;
        nx = st;
        // one wait state: pready rises in the second access cycle, for one cycle
        nx.pready = psel && penable && !st.pready;
        nx.pslverr = psel && penable && !st.pready && !mapped;
        nx.prdata = 32'h0;
        if (rd_en && mapped) begin
            if (off == SPF_OFF_SUB_RES) begin
                nx.prdata = {16'h0, st.sub_res};
            end else if (off == SPF_OFF_MAIN_RES) begin
                nx.prdata = {16'h0, st.main_res};
            end else if (off == SPF_OFF_SUB_EXT) begin
                nx.prdata = {16'h0, st.sub_ext};
            end else if (off == SPF_OFF_MAIN_EXT) begin
                nx.prdata = {16'h0, st.main_ext};
            end else if (off == SPF_OFF_LOOP) begin
                nx.prdata = {16'h0, st.loop_type};
            end else if (off == SPF_OFF_ORE) begin
                nx.prdata = {16'h0, st.overrun_width};
            end else if (off == SPF_OFF_FUNC7) begin
                nx.prdata = {16'h0, st.func7};
            end else if (off == SPF_OFF_FUNC5) begin
                nx.prdata = {16'h0, st.func5};
            end else if (off == SPF_OFF_ZRN) begin
                nx.prdata = {16'h0, st.zrn};
            end else if (off == SPF_OFF_MAXSPD) begin
                nx.prdata = {16'h0, st.maxspd};
            end else if (off == SPF_OFF_STATUS) begin
                nx.prdata = {8'h0, st.alarm ? SPF_ALARM_OVERRUN : 8'h00, 5'h0,
                    st.prox_seen, st.zd == SPF_ZD_DONE, st.zd == SPF_ZD_RUN, st.cfg_err};
            end else if (off == SPF_OFF_INT_STAT) begin
                nx.prdata = {28'h0, st.int_stat};
            end else if (off == SPF_OFF_INT_EN) begin
                nx.prdata = {28'h0, st.int_en};
            end else if (off == SPF_OFF_SUB_PULSES) begin
                nx.prdata = sub_pulses;
            end else if (off == SPF_OFF_MAIN_PULSES) begin
                nx.prdata = main_pulses;
            end
        end
        // register writes; status words ignore writes
        if (wr_en) begin
            if (off == SPF_OFF_SUB_RES) begin
                nx.sub_res = pwdata[15:0];
            end else if (off == SPF_OFF_MAIN_RES) begin
                nx.main_res = pwdata[15:0];
            end else if (off == SPF_OFF_SUB_EXT) begin
                nx.sub_ext = pwdata[15:0];
            end else if (off == SPF_OFF_MAIN_EXT) begin
                nx.main_ext = pwdata[15:0];
            end else if (off == SPF_OFF_LOOP) begin
                nx.loop_type = pwdata[15:0];
            end else if (off == SPF_OFF_ORE) begin
                nx.overrun_width = pwdata[15:0];
            end else if (off == SPF_OFF_FUNC7) begin
                nx.func7 = pwdata[15:0];
            end else if (off == SPF_OFF_FUNC5) begin
                nx.func5 = pwdata[15:0];
            end else if (off == SPF_OFF_ZRN) begin
                nx.zrn = pwdata[15:0];
            end else if (off == SPF_OFF_MAXSPD) begin
                nx.maxspd = pwdata[15:0];
            end else if (off == SPF_OFF_INT_EN) begin
                nx.int_en = pwdata[SPF_NIRQ-1:0];
            end else if (off == SPF_OFF_INT_CLR) begin
                clr_ev = pwdata[SPF_NIRQ-1:0];
            end
        end
        nx.cfg_err = cfg_now;
        // R17 zero point search after first speed command
        nx.prox_prev = prox_in;
        case (st.zd)
            SPF_ZD_IDLE: begin
                if (speed_cmd) begin
                    nx.zd = SPF_ZD_RUN;
                    nx.z_count = 2'd0;
                end
            end
            SPF_ZD_RUN: begin
                if (sel_prox && prox_edge && !st.prox_seen) begin
                    nx.prox_seen = 1'b1;
                    set_ev[SPF_IRQ_PROX] = 1'b1;
                end
                if (z_phase) begin
                    nx.z_count = st.z_count + 2'd1;
                    if (st.z_count == 2'd1) begin
                        nx.zd = SPF_ZD_DONE;
                        set_ev[SPF_IRQ_ZDONE] = 1'b1;
                    end
                end
            end
            default: begin
                nx.zd = SPF_ZD_DONE;
            end
        endcase
        // search flag registered so the pin comes straight from a flop
        nx.zdet = (nx.zd == SPF_ZD_RUN);
        // R10 overrun raises the alarm
        set_ev[SPF_IRQ_OVERRUN] = overrun_hit;
        set_ev[SPF_IRQ_CFG] = (cfg_now != 8'h00) && (st.cfg_err == 8'h00);
        // a new event wins over a clear in the same cycle
        nx.int_stat = (st.int_stat & ~clr_ev) | set_ev;
        nx.alarm = nx.int_stat[SPF_IRQ_OVERRUN];
        nx.irq = |(nx.int_stat & nx.int_en);
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.sub_res <= SPF_RST_RES;
            st.main_res <= SPF_RST_RES;
            st.loop_type <= SPF_LOOP_SEMI;
            st.maxspd <= SPF_RST_MAXSPD;
            st.zd <= SPF_ZD_IDLE;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from the state register
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign prdata = st.prdata;
    assign zdet_active = st.zdet;
    assign prox_seen = st.prox_seen;
    assign alarm_overrun = st.alarm;
    assign irq = st.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_apb_wait_state: assert property (psel && penable && !pready |=> pready) // bus
        else $error("pready did not follow the first access cycle");
    a_apb_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_overrun_alarm: assert property (overrun_hit |=> alarm_overrun) // R10
        else $error("overrun did not raise the alarm");
    a_overrun_semi: assert property (semi_loop && !alarm_overrun
        && !($past(overrun_hit)) |-> !overrun_hit) // R09
        else $error("overrun seen in semi-closed loop");
    a_alarm_sticky: assert property (alarm_overrun && !(wr_en && off == SPF_OFF_INT_CLR)
        |=> alarm_overrun) // R10
        else $error("alarm dropped without a clear");
    a_sub_kp_unit: assert property (st.sub_ext == 16'h0000
        |-> sub_pulses == {16'h0000, st.sub_res} * SPF_KP_SCALE) // R04
        else $error("sub resolution not in kilopulses");
    a_main_pulse_join: assert property (st.main_ext != 16'h0000 && st.main_ext != SPF_NEG1
        |-> main_pulses == {st.main_ext, st.main_res}) // R08
        else $error("main resolution halves misplaced");
    a_ore_zero_width: assert property (st.overrun_width == 16'h0000 |-> width_eff == 16'h0002) // R12
        else $error("zero width not two degrees");
    a_semi_mismatch: assert property (semi_loop && st.sub_res != st.main_res
        |=> st.cfg_err[1]) // R01
        else $error("semi loop mismatch not flagged");
    a_zdet_start: assert property (st.zd == SPF_ZD_IDLE && speed_cmd |=> zdet_active) // R17
        else $error("zero detect did not start");
    a_zdet_two_z: assert property (zdet_active && z_phase && st.z_count == 2'd1
        |=> !zdet_active ##0 st.int_stat[SPF_IRQ_ZDONE]) // R17
        else $error("zero detect did not end on second Z");
    a_irq_level: assert property (irq == |(st.int_stat & st.int_en))
        else $error("irq disagrees with enabled status");
endmodule // spf_feedback
`default_nettype wire

// [test/spf_enc_model.sv]
// Purpose: behavioural motor side and machine side encoders with a proximity switch
// Assumes: both counts start at zero together after reset
// Notes: the bench sets position and speed gaps directly; the switch level passes through
`default_nettype none
module spf_enc_model
    import spf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic turn,
    input wire logic signed [31:0] pos_gap,
    input wire logic signed [15:0] spd_gap,
    input wire logic prox_lvl,
    output var spf_fb_t fb,
    output logic z_phase,
    output logic prox_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic signed [31:0] motor_pos;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            motor_pos <= 32'sh0;
            z_phase <= 1'b0;
        end else begin
            motor_pos <= motor_pos + (turn ? 32'sh1 : 32'sh0);
            z_phase <= turn && (motor_pos[2:0] == 3'h7); // short marker, no stretch
        end
    end
    // machine side trails the motor side by the commanded gap
    always_comb begin
        fb.motor_count = motor_pos;
        fb.machine_count = motor_pos - pos_gap;
        fb.motor_speed = 16'sh03e8;
        fb.machine_speed = 16'sh03e8 - spd_gap;
    end
    assign prox_in = prox_lvl;
endmodule // spf_enc_model
`default_nettype wire

// [test/tb_spindle_encoder_feedback_config.sv]
// Purpose: self-checking bench for the spindle feedback configuration block
// Assumes: APB slave with one wait state, encoder model on the feedback side
// Notes: expectations come from integer helpers, never from design outputs
`default_nettype none
module tb_spindle_encoder_feedback_config
    import spf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic speed_cmd = 1'b0, turn = 1'b0, prox_lvl = 1'b0, err;
    logic pready, pslverr, z_phase, prox_in, zdet_active, prox_seen, alarm_overrun, irq;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd, lfsr = 32'h3231;
    logic signed [31:0] pos_gap = 32'sh0;
    logic signed [15:0] spd_gap = 16'sh0;
    spf_fb_t fb;
    int n_errors = 0, comparisons = 0;
    logic [7:0] r_off[5] = '{SPF_OFF_SUB_RES, SPF_OFF_MAIN_RES, SPF_OFF_LOOP, SPF_OFF_MAXSPD,
        SPF_OFF_ORE};
    int r_val[5] = '{2000, 2000, 2200, 10000, 0};
    int codes[4] = '{2200, 4200, 6200, 1234};
    // config error bits per loop code, with the resolutions left by the decode test
    int cfg_exp[4] = '{2, 0, 0, 1};
    // overrun cases: width, position gap, speed gap, alarm expected
    int oc[6][4] = '{'{0, 2, 0, 0}, '{0, 3, 0, 1}, '{360, 360, 0, 0}, '{360, 361, 0, 1},
        '{65535, 0, 3000, 0}, '{65535, 0, 3001, 1}};

    spf_feedback u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .fb_in(fb), .speed_cmd(speed_cmd), .z_phase(z_phase), .prox_in(prox_in),
        .zdet_active(zdet_active), .prox_seen(prox_seen), .alarm_overrun(alarm_overrun),
        .irq(irq));
    spf_enc_model u_enc (.clk(clk), .rst(rst), .turn(turn), .pos_gap(pos_gap),
        .spd_gap(spd_gap), .prox_lvl(prox_lvl), .fb(fb), .z_phase(z_phase), .prox_in(prox_in));

    initial begin
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // pulses per turn: kilopulses when the extension is zero, -1 keeps the word alone
    function automatic logic [31:0] exp_pulses(input int ext, input int word);
        if (ext == 0) return word * 1000;
        if (ext == 65535) return word;
        return ext * 65536 + word;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until the edge that sees pready; data taken at that same edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("access cycles", 32'd2, 32'(n)); // one wait state
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        int w;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (r_off[i]) rdchk(r_off[i], r_val[i], "reset value");
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("test reset done");
        lfsr = next_rand(lfsr);
        w = int'(lfsr[14:0]);
        wr(SPF_OFF_SUB_EXT, 32'h0);
        wr(SPF_OFF_SUB_RES, w);
        rdchk(SPF_OFF_SUB_PULSES, exp_pulses(0, w), "sub kp");
        wr(SPF_OFF_MAIN_EXT, 32'h1);
        wr(SPF_OFF_MAIN_RES, {16'h0, lfsr[15:0]});
        rdchk(SPF_OFF_MAIN_PULSES, exp_pulses(1, int'(lfsr[15:0])), "main p");
        wr(SPF_OFF_SUB_EXT, 32'hffff);
        wr(SPF_OFF_SUB_RES, 32'd4096);
        rdchk(SPF_OFF_SUB_PULSES, exp_pulses(65535, 4096), "sub abz");
        wr(SPF_OFF_MAIN_EXT, 32'h0);
        wr(SPF_OFF_MAIN_RES, 32'd32767);
        rdchk(SPF_OFF_MAIN_PULSES, exp_pulses(0, 32767), "main kp max");
        $display("test decode done");
        foreach (codes[i]) begin
            wr(SPF_OFF_LOOP, codes[i]);
            rdchk(SPF_OFF_STATUS, cfg_exp[i], "status cfg");
        end
        apb(1'b0, SPF_OFF_STATUS, 32'h0);
        chk("unknown loop", 32'h1, {31'h0, rd[0]});
        wr(SPF_OFF_LOOP, 32'd2200);
        apb(1'b0, SPF_OFF_STATUS, 32'h0);
        chk("semi mismatch", 32'h1, {31'h0, rd[1]});
        wr(SPF_OFF_MAIN_EXT, 32'hffff);
        wr(SPF_OFF_MAIN_RES, 32'd4096);
        rdchk(SPF_OFF_STATUS, 32'h0, "semi match");
        wr(SPF_OFF_LOOP, 32'd4200);
        rdchk(SPF_OFF_STATUS, 32'h0, "abz ok");
        wr(SPF_OFF_SUB_RES, 32'd360);
        apb(1'b0, SPF_OFF_STATUS, 32'h0);
        chk("abz wrong", 32'h1, {31'h0, rd[2]});
        $display("test loop type done");
        wr(SPF_OFF_LOOP, 32'd6200);
        wr(SPF_OFF_MAIN_RES, 32'd360);
        wr(SPF_OFF_INT_EN, 32'h1);
        wr(SPF_OFF_INT_CLR, 32'hf);
        // normal width 360 and belt drive -1 among the cases
        foreach (oc[i]) begin
            wr(SPF_OFF_ORE, oc[i][0]);
            pos_gap <= oc[i][1];
            spd_gap <= 16'(oc[i][2]);
            cyc(2);
            chk("alarm", oc[i][3], {31'h0, alarm_overrun});
            chk("irq", oc[i][3], {31'h0, irq});
            pos_gap <= 32'sh0;
            spd_gap <= 16'sh0;
            wr(SPF_OFF_INT_CLR, 32'h1);
            cyc(2);
            chk("alarm clear", 32'h0, {31'h0, alarm_overrun});
        end
        wr(SPF_OFF_INT_EN, 32'h0);
        wr(SPF_OFF_ORE, 32'h0);
        pos_gap <= 32'sh3;
        cyc(2);
        chk("masked irq", 32'h0, {31'h0, irq});
        apb(1'b0, SPF_OFF_STATUS, 32'h0);
        chk("alarm code", 32'd43, {24'h0, rd[23:16]});
        rdchk(SPF_OFF_INT_STAT, 32'h1, "int status");
        wr(SPF_OFF_LOOP, 32'd2200);
        wr(SPF_OFF_INT_CLR, 32'hf);
        pos_gap <= 32'sh64;
        cyc(2);
        chk("semi no alarm", 32'h0, {31'h0, alarm_overrun});
        $display("test overrun done");
        pos_gap <= 32'sh0;
        wr(SPF_OFF_FUNC7, 32'h4000);
        wr(SPF_OFF_FUNC5, 32'h0020);
        wr(SPF_OFF_ZRN, 32'h8000);
        wr(SPF_OFF_INT_CLR, 32'hf);
        @(posedge clk);
        speed_cmd <= 1'b1;
        @(posedge clk);
        speed_cmd <= 1'b0;
        turn <= 1'b1;
        cyc(1);
        chk("search running", 32'h1, {31'h0, zdet_active});
        @(posedge clk);
        prox_lvl <= 1'b1;
        w = 0;
        while (zdet_active === 1'b1 && w < 100) begin
            cyc(1);
            w++;
        end
        chk("search ended", 32'h0, {31'h0, zdet_active});
        chk("prox seen", 32'h1, {31'h0, prox_seen});
        apb(1'b0, SPF_OFF_INT_STAT, 32'h0);
        chk("search events", 32'h3, {30'h0, rd[3:2]});
        $display("test zero search done");
        end_of_test();
    end
endmodule // tb_spindle_encoder_feedback_config
`default_nettype wire
